// *** rtl/e1os_defs.vh ***
// constants for the e1 overhead source and line mode block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef E1OS_DEFS_VH
`define E1OS_DEFS_VH

// register indices, byte address is four times the index
`define E1OS_IDX_MODE 9'h000
`define E1OS_IDX_FRMCTL 9'h001
`define E1OS_IDX_OHSRC 9'h002
`define E1OS_IDX_AFR 9'h003
`define E1OS_IDX_NAFR 9'h004
`define E1OS_IDX_ALIGN_SI_ENABLE 9'h005
`define E1OS_IDX_NONALIGN_SI_ENABLE 9'h006
`define E1OS_IDX_SA4 9'h007
`define E1OS_IDX_SA8 9'h00b
`define E1OS_IDX_RXLINE 9'h00c
`define E1OS_IDX_TXLINE 9'h00d
`define E1OS_IDX_CLKCTL 9'h00e
`define E1OS_IDX_STATUS 9'h00f
`define E1OS_IDX_TUNA1 9'h195
`define E1OS_IDX_TUNB1 9'h199
`define E1OS_IDX_TUNA2 9'h1a5
`define E1OS_IDX_TUNB2 9'h1a9
`define E1OS_IDX_PAGE 9'h1ff

// field positions
`define E1OS_MODE_TX_LSB 0
`define E1OS_MODE_RX_LSB 2
`define E1OS_FRM_PASS 0
`define E1OS_FRM_CRC4 1
`define E1OS_FRM_SIS 2
`define E1OS_OH_ALIGN_SI_ENABLE 0
`define E1OS_OH_NONALIGN_SI_ENABLE 1
`define E1OS_OH_SA_LSB 2
`define E1OS_TXL_LBO_LSB 3
`define E1OS_ST_AF 0
`define E1OS_ST_MF 1
`define E1OS_ST_OVR 2
`define E1OS_ST_RXOK 3
`define E1OS_ST_TXOK 4

// line modes and codes
`define E1OS_LM_E1 2'h1
`define E1OS_LM_2048 2'h2
`define E1OS_LM_6312 2'h3
`define E1OS_IMP_75 3'h0
`define E1OS_IMP_120 3'h3
`define E1OS_LBO_75 3'h0
`define E1OS_LBO_120 3'h1
`define E1OS_PAGE_OPEN 8'h01

// reset values and fixed patterns
`define E1OS_RST_BYTE 8'h00
`define E1OS_RST_MODE 2'h0
`define E1OS_MFAS_PAT 8'h2f
`define E1OS_LAST_BIT 8'hff

`endif

// *** rtl/e1os_fifo.v ***
// small flip-flop fifo with a registered output stage
`timescale 1ns/1ps
module e1os_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  // refill the output stage whenever it is empty or being taken
  assign pop = (cnt_reg != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem[wr_reg] <= in_data;
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_reg];
        rd_reg <= rd_reg + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // e1os_fifo

// *** rtl/e1os_top.v ***
// e1 transmit overhead source selection, line modes and apb registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "e1os_defs.vh"
module e1os_top (
  // clock and reset
  input wire mclk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg pslverr,
  output reg [31:0] prdata,
  // line side pins
  input wire tx_line_clock_pin,
  input wire tx_serial_in_pin,
  // formatted bit stream to the line encoder
  output wire tx_bit_data,
  output wire tx_bit_valid,
  input wire tx_bit_ready,
  // line configuration to the analog front end
  output reg [1:0] rx_line_mode,
  output reg [1:0] tx_line_mode,
  output reg [2:0] rx_impedance_code,
  output reg [2:0] tx_impedance_code,
  output reg [2:0] line_buildout_code,
  output reg [7:0] tuning_a_channel_one,
  output reg [7:0] tuning_b_channel_one,
  output reg [7:0] tuning_a_channel_two,
  output reg [7:0] tuning_b_channel_two
);
  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  reg [2:0] tx_framer_control_four;
  reg [6:0] overhead_source_control;
  reg [7:0] align_frame_overhead_reg;
  reg [7:0] nonalign_frame_overhead_reg;
  reg [7:0] align_si_reg;
  reg [7:0] nonalign_si_reg;
  reg [39:0] sa_channel_reg;
  reg [7:0] hidden_page_select;
  reg tx_clock_invert;
  reg af_flag_reg;
  reg mf_flag_reg;
  reg ovr_flag_reg;

  // ----------------------------------------------------------------
  // framer state
  // ----------------------------------------------------------------
  reg [7:0] af_sh_reg;
  reg [7:0] naf_sh_reg;
  reg [7:0] align_si_enable_sh_reg;
  reg [7:0] nonalign_si_enable_sh_reg;
  reg [39:0] sa_sh_reg;
  reg [7:0] bit_cnt_reg;
  reg [3:0] frame_cnt_reg;
  reg [3:0] crc_reg;
  reg [3:0] crc_hold_reg;
  reg clk_prev_reg;
  reg pend_reg;
  reg pin_hold_reg;

  wire framing_passthrough = tx_framer_control_four[`E1OS_FRM_PASS];
  wire tx_crc4_mode = tx_framer_control_four[`E1OS_FRM_CRC4];
  wire si_source_select = tx_framer_control_four[`E1OS_FRM_SIS];
  wire align_si_enable = overhead_source_control[`E1OS_OH_ALIGN_SI_ENABLE];
  wire nonalign_si_enable = overhead_source_control[`E1OS_OH_NONALIGN_SI_ENABLE];
  wire [4:0] sa_channel_enable = overhead_source_control[6:2];

  // ----------------------------------------------------------------
  // line configuration checks
  // ----------------------------------------------------------------
  reg rx_ok;
  reg tx_ok;
  always @* begin
    rx_ok = 1'b1;
    if (rx_line_mode == `E1OS_LM_2048) begin
      rx_ok = (rx_impedance_code == `E1OS_IMP_75) | (rx_impedance_code == `E1OS_IMP_120);
    end else if (rx_line_mode == `E1OS_LM_6312) begin
      rx_ok = (rx_impedance_code == `E1OS_IMP_75);
    end
    tx_ok = 1'b1;
    if (tx_line_mode == `E1OS_LM_2048) begin
      tx_ok = ((tx_impedance_code == `E1OS_IMP_75) | (tx_impedance_code == `E1OS_IMP_120)) &
              ((line_buildout_code == `E1OS_LBO_75) | (line_buildout_code == `E1OS_LBO_120));
    end
  end

  // ----------------------------------------------------------------
  // line clock sampling
  // ----------------------------------------------------------------
  wire clk_rise = ~clk_prev_reg & tx_line_clock_pin;
  wire clk_fall = clk_prev_reg & ~tx_line_clock_pin;
  wire strobe = tx_clock_invert ? clk_rise : clk_fall;
  wire fifo_in_ready;
  wire step = pend_reg & fifo_in_ready;
  wire run_e1 = (tx_line_mode == `E1OS_LM_E1);
  wire run_2048 = (tx_line_mode == `E1OS_LM_2048);

  // ----------------------------------------------------------------
  // overhead source selection
  // ----------------------------------------------------------------
  wire ts0 = (bit_cnt_reg[7:3] == 5'h00);
  wire [2:0] pos = bit_cnt_reg[2:0];
  wire [2:0] oh_idx = 3'd7 - pos;
  wire is_align = ~frame_cnt_reg[0];
  wire [2:0] mf_idx = 3'd7 - frame_cnt_reg[3:1];
  wire [2:0] sa_ch = pos - 3'd3;
  wire [5:0] sa_idx = {sa_ch, mf_idx};
  wire [1:0] c_idx = 2'd3 - frame_cnt_reg[2:1];
  wire [7:0] mfas_pat = `E1OS_MFAS_PAT;
  reg out_bit;
  reg crc_in;

  // each position of time slot zero picks its own source
  always @* begin
    out_bit = pin_hold_reg;
    if (ts0 & is_align) begin
      if (pos == 3'd0) begin
        if (align_si_enable) begin
          out_bit = align_si_enable_sh_reg[mf_idx];
        end else if (tx_crc4_mode) begin
          out_bit = crc_hold_reg[c_idx];
        end else if (~si_source_select | framing_passthrough) begin
          out_bit = pin_hold_reg;
        end else begin
          out_bit = af_sh_reg[oh_idx];
        end
      end else begin
        out_bit = framing_passthrough ? pin_hold_reg : af_sh_reg[oh_idx];
      end
    end else if (ts0) begin
      if (pos == 3'd0) begin
        if (nonalign_si_enable) begin
          out_bit = nonalign_si_enable_sh_reg[mf_idx];
        end else if (tx_crc4_mode) begin
          out_bit = mfas_pat[mf_idx];
        end else if (~si_source_select | framing_passthrough) begin
          out_bit = pin_hold_reg;
        end else begin
          out_bit = naf_sh_reg[oh_idx];
        end
      end else if ((pos >= 3'd3) && sa_channel_enable[sa_ch]) begin
        out_bit = sa_sh_reg[sa_idx];
      end else begin
        out_bit = framing_passthrough ? pin_hold_reg : naf_sh_reg[oh_idx];
      end
    end
    // c bit slots count as zero in the checksum
    crc_in = (tx_crc4_mode & ts0 & is_align & (pos == 3'd0)) ? 1'b0 : out_bit;
  end

  wire crc_fb = crc_reg[3] ^ crc_in;
  wire [3:0] crc_nx = {crc_reg[2:0], 1'b0} ^ {2'b00, crc_fb, crc_fb};
  wire last_bit = (bit_cnt_reg == `E1OS_LAST_BIT);
  wire af_start = last_bit & frame_cnt_reg[0];
  wire mf_start = last_bit & (frame_cnt_reg == 4'hf);
  wire smf_end = last_bit & (frame_cnt_reg[2:0] == 3'h7);
  // 2048 mode is unframed all ones
  wire fifo_bit = run_2048 ? 1'b1 : out_bit;

  // ----------------------------------------------------------------
  // framer sequencing
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_prev_reg <= 1'b0;
      pend_reg <= 1'b0;
      pin_hold_reg <= 1'b0;
      bit_cnt_reg <= 8'h00;
      frame_cnt_reg <= 4'h0;
      crc_reg <= 4'h0;
      crc_hold_reg <= 4'h0;
      af_sh_reg <= `E1OS_RST_BYTE;
      naf_sh_reg <= `E1OS_RST_BYTE;
      align_si_enable_sh_reg <= `E1OS_RST_BYTE;
      nonalign_si_enable_sh_reg <= `E1OS_RST_BYTE;
      sa_sh_reg <= {5{`E1OS_RST_BYTE}};
    end else begin
      clk_prev_reg <= tx_line_clock_pin;
      // a strobe waits in pend while the fifo is full
      if (strobe & (run_e1 | run_2048)) begin
        pend_reg <= 1'b1;
        pin_hold_reg <= tx_serial_in_pin;
      end else if (step | ~(run_e1 | run_2048)) begin
        pend_reg <= 1'b0;
      end
      if (step & run_e1) begin
        bit_cnt_reg <= bit_cnt_reg + 8'h01;
        if (last_bit) begin
          frame_cnt_reg <= frame_cnt_reg + 4'h1;
        end
        if (smf_end) begin
          crc_hold_reg <= crc_nx;
          crc_reg <= 4'h0;
        end else begin
          crc_reg <= crc_nx;
        end
        if (af_start) begin
          af_sh_reg <= align_frame_overhead_reg;
          naf_sh_reg <= nonalign_frame_overhead_reg;
        end
        if (mf_start) begin
          align_si_enable_sh_reg <= align_si_reg;
          nonalign_si_enable_sh_reg <= nonalign_si_reg;
          sa_sh_reg <= sa_channel_reg;
        end
      end
    end
  end

  e1os_fifo #(
    .WIDTH(1),
    .DEPTH(16),
    .AW(4)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(step),
    .in_ready(fifo_in_ready),
    .in_data(fifo_bit),
    .out_valid(tx_bit_valid),
    .out_ready(tx_bit_ready),
    .out_data(tx_bit_data)
  );

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire [8:0] idx = paddr[10:2];
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready & pwrite;
  wire page_open = (hidden_page_select == `E1OS_PAGE_OPEN);
  wire clr_af = wr_go & (idx == `E1OS_IDX_STATUS) & pwdata[`E1OS_ST_AF];
  wire clr_mf = wr_go & (idx == `E1OS_IDX_STATUS) & pwdata[`E1OS_ST_MF];
  wire clr_ovr = wr_go & (idx == `E1OS_IDX_STATUS) & pwdata[`E1OS_ST_OVR];
  wire [2:0] sa_w = idx[2:0] - 3'd7;
  reg [31:0] rd_next;
  reg hit;

  always @* begin
    rd_next = 32'h0000_0000;
    hit = ~paddr[11];
    case (idx)
      `E1OS_IDX_MODE: rd_next[3:0] = {rx_line_mode, tx_line_mode};
      `E1OS_IDX_FRMCTL: rd_next[2:0] = tx_framer_control_four;
      `E1OS_IDX_OHSRC: rd_next[6:0] = overhead_source_control;
      `E1OS_IDX_AFR: rd_next[7:0] = align_frame_overhead_reg;
      `E1OS_IDX_NAFR: rd_next[7:0] = nonalign_frame_overhead_reg;
      `E1OS_IDX_ALIGN_SI_ENABLE: rd_next[7:0] = align_si_reg;
      `E1OS_IDX_NONALIGN_SI_ENABLE: rd_next[7:0] = nonalign_si_reg;
      9'h007, 9'h008, 9'h009, 9'h00a, `E1OS_IDX_SA8: rd_next[7:0] = sa_channel_reg[{sa_w, 3'b000} +: 8];
      `E1OS_IDX_RXLINE: rd_next[2:0] = rx_impedance_code;
      `E1OS_IDX_TXLINE: rd_next[5:0] = {line_buildout_code, tx_impedance_code};
      `E1OS_IDX_CLKCTL: rd_next[0] = tx_clock_invert;
      `E1OS_IDX_STATUS: rd_next[4:0] = {tx_ok, rx_ok, ovr_flag_reg, mf_flag_reg, af_flag_reg};
      `E1OS_IDX_TUNA1: rd_next[7:0] = tuning_a_channel_one;
      `E1OS_IDX_TUNB1: rd_next[7:0] = tuning_b_channel_one;
      `E1OS_IDX_TUNA2: rd_next[7:0] = tuning_a_channel_two;
      `E1OS_IDX_TUNB2: rd_next[7:0] = tuning_b_channel_two;
      `E1OS_IDX_PAGE: rd_next[7:0] = hidden_page_select;
      default: hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      rx_line_mode <= `E1OS_RST_MODE;
      tx_line_mode <= `E1OS_RST_MODE;
      tx_framer_control_four <= 3'h0;
      overhead_source_control <= 7'h00;
      align_frame_overhead_reg <= `E1OS_RST_BYTE;
      nonalign_frame_overhead_reg <= `E1OS_RST_BYTE;
      align_si_reg <= `E1OS_RST_BYTE;
      nonalign_si_reg <= `E1OS_RST_BYTE;
      sa_channel_reg <= {5{`E1OS_RST_BYTE}};
      rx_impedance_code <= 3'h0;
      tx_impedance_code <= 3'h0;
      line_buildout_code <= 3'h0;
      tx_clock_invert <= 1'b0;
      tuning_a_channel_one <= `E1OS_RST_BYTE;
      tuning_b_channel_one <= `E1OS_RST_BYTE;
      tuning_a_channel_two <= `E1OS_RST_BYTE;
      tuning_b_channel_two <= `E1OS_RST_BYTE;
      hidden_page_select <= `E1OS_RST_BYTE;
      af_flag_reg <= 1'b0;
      mf_flag_reg <= 1'b0;
      ovr_flag_reg <= 1'b0;
    end else begin
      // answer in the first access cycle, one wait-free transfer
      pready <= setup;
      if (setup) begin
        // refused reads return zero, not the aliased index
        prdata <= (pwrite | ~hit) ? 32'h0000_0000 : rd_next;
        pslverr <= ~hit;
      end else begin
        pslverr <= 1'b0;
      end
      // latched flags: a new event beats a same-cycle clear
      af_flag_reg <= (step & run_e1 & af_start) | (af_flag_reg & ~clr_af);
      mf_flag_reg <= (step & run_e1 & mf_start) | (mf_flag_reg & ~clr_mf);
      ovr_flag_reg <= (strobe & pend_reg & ~step) | (ovr_flag_reg & ~clr_ovr);
      if (wr_go & hit) begin
        case (idx)
          `E1OS_IDX_MODE: begin
            rx_line_mode <= pwdata[`E1OS_MODE_RX_LSB +: 2];
            // no 6312 transmit mode: such a write keeps the old mode
            if (pwdata[`E1OS_MODE_TX_LSB +: 2] != `E1OS_LM_6312) begin
              tx_line_mode <= pwdata[`E1OS_MODE_TX_LSB +: 2];
            end
          end
          `E1OS_IDX_FRMCTL: tx_framer_control_four <= pwdata[2:0];
          `E1OS_IDX_OHSRC: overhead_source_control <= pwdata[6:0];
          `E1OS_IDX_AFR: align_frame_overhead_reg <= pwdata[7:0];
          `E1OS_IDX_NAFR: nonalign_frame_overhead_reg <= pwdata[7:0];
          `E1OS_IDX_ALIGN_SI_ENABLE: align_si_reg <= pwdata[7:0];
          `E1OS_IDX_NONALIGN_SI_ENABLE: nonalign_si_reg <= pwdata[7:0];
          9'h007, 9'h008, 9'h009, 9'h00a, `E1OS_IDX_SA8: sa_channel_reg[{sa_w, 3'b000} +: 8] <= pwdata[7:0];
          `E1OS_IDX_RXLINE: rx_impedance_code <= pwdata[2:0];
          `E1OS_IDX_TXLINE: begin
            tx_impedance_code <= pwdata[2:0];
            line_buildout_code <= pwdata[`E1OS_TXL_LBO_LSB +: 3];
          end
          `E1OS_IDX_CLKCTL: tx_clock_invert <= pwdata[0];
          `E1OS_IDX_PAGE: hidden_page_select <= pwdata[7:0];
          // tuning locations only take writes while the page is open
          `E1OS_IDX_TUNA1: if (page_open) tuning_a_channel_one <= pwdata[7:0];
          `E1OS_IDX_TUNB1: if (page_open) tuning_b_channel_one <= pwdata[7:0];
          `E1OS_IDX_TUNA2: if (page_open) tuning_a_channel_two <= pwdata[7:0];
          `E1OS_IDX_TUNB2: if (page_open) tuning_b_channel_two <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end
endmodule // e1os_top

// *** tb/e1os_top_monitor.sv ***
// port checker for the e1 overhead source top block
`timescale 1ns/1ps
module e1os_top_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // stream and line configuration
  input wire logic tx_bit_data,
  input wire logic tx_bit_valid,
  input wire logic tx_bit_ready,
  input wire logic [1:0] rx_line_mode,
  input wire logic [1:0] tx_line_mode,
  input wire logic [2:0] rx_impedance_code,
  input wire logic [2:0] tx_impedance_code,
  input wire logic [2:0] line_buildout_code,
  input wire logic [7:0] tuning_a_channel_one,
  input wire logic [7:0] tuning_b_channel_two
);
  // ------
  // last completed write, one cycle late
  // ------
  logic wr_reg;
  logic [11:0] wa_reg;
  logic [31:0] wd_reg;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_reg <= 1'b0;
      wa_reg <= 12'h0;
      wd_reg <= 32'h0;
    end else begin
      wr_reg <= psel && penable && pready && pwrite;
      wa_reg <= paddr;
      wd_reg <= pwdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------
  // assertions
  // ------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_unmapped_error: assert property (psel && !penable && (paddr[11] || paddr[1:0] != 2'b00)
    |=> pready && pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_rx_mode_write: assert property (wr_reg && wa_reg == 12'h000 |-> rx_line_mode == wd_reg[3:2])
    else $error("rx mode not written");
  a_tx_mode_write: assert property (wr_reg && wa_reg == 12'h000 && wd_reg[1:0] != 2'b11
    |-> tx_line_mode == wd_reg[1:0]) else $error("tx mode not written");
  a_tx_mode_keep: assert property (wr_reg && wa_reg == 12'h000 && wd_reg[1:0] == 2'b11
    |-> $stable(tx_line_mode)) else $error("tx mode took the 6312 code");
  a_rx_imp_write: assert property (wr_reg && wa_reg == 12'h030 |-> rx_impedance_code == wd_reg[2:0])
    else $error("rx impedance not written");
  a_tx_line_write: assert property (wr_reg && wa_reg == 12'h034
    |-> {line_buildout_code, tx_impedance_code} == wd_reg[5:0]) else $error("tx line codes not written");
  a_tuning_a_source: assert property (!$stable(tuning_a_channel_one)
    |-> wr_reg && wa_reg == 12'h654 && tuning_a_channel_one == wd_reg[7:0]) else $error("tuning a moved");
  a_tuning_b_source: assert property (!$stable(tuning_b_channel_two)
    |-> wr_reg && wa_reg == 12'h6a4 && tuning_b_channel_two == wd_reg[7:0]) else $error("tuning b moved");
  a_stream_hold: assert property (tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit_data))
    else $error("stalled bit dropped or changed");
  c_tuning_write: cover property (wr_reg && wa_reg == 12'h654);
  c_stream_stall: cover property (tx_bit_valid && !tx_bit_ready);
  c_error: cover property (pready && pslverr);
endmodule // e1os_top_monitor

bind e1os_top e1os_top_monitor e1os_top_monitor_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .prdata, .tx_bit_data, .tx_bit_valid, .tx_bit_ready, .rx_line_mode, .tx_line_mode,
  .rx_impedance_code, .tx_impedance_code, .line_buildout_code, .tuning_a_channel_one, .tuning_b_channel_two);

// *** tb/e1os_line_model.sv ***
// far side of the line: line clock, serial pin and bit sink
`timescale 1ns/1ps
module e1os_line_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench control
  input wire logic run,
  input wire logic stall,
  input wire logic hi_val,
  // formatted bits from the block
  input wire logic tx_bit_data,
  input wire logic tx_bit_valid,
  // line pins
  output logic tx_line_clock_pin = 1'b0,
  output logic tx_serial_in_pin = 1'b0,
  output logic tx_bit_ready = 1'b0
);
  logic [2:0] ph = 3'h0;
  logic [1023:0] bits = '0;
  int nbits = 0;
  // six mclk per bit, clock idles low when not running
  always @(posedge mclk) begin
    if (rst) begin
      ph <= 3'h0;
      nbits <= 0;
      tx_line_clock_pin <= 1'b0;
    end else begin
      ph <= (run && ph != 3'h5) ? ph + 3'h1 : 3'h0;
      tx_line_clock_pin <= run && ph < 3'h3;
    end
    // pin moves one mclk after each clock edge, so the two edges see opposite levels
    tx_serial_in_pin <= tx_line_clock_pin ? hi_val : !hi_val;
    tx_bit_ready <= !stall;
    if (!rst && tx_bit_valid && tx_bit_ready && nbits < 1024) begin
      bits[nbits] <= tx_bit_data;
      nbits <= nbits + 1;
    end
  end
endmodule // e1os_line_model

// *** tb/e1os_top_bench.sv ***
// self-checking bench for the e1 overhead source top block
`timescale 1ns/1ps
`include "e1os_defs.vh"
module e1os_top_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, tx_bit_data, tx_bit_valid, tx_bit_ready, tx_line_clock_pin, tx_serial_in_pin;
  logic [1:0] rx_line_mode, tx_line_mode;
  logic [2:0] rx_impedance_code, tx_impedance_code, line_buildout_code;
  logic [7:0] tuning_a_channel_one, tuning_b_channel_one, tuning_a_channel_two, tuning_b_channel_two;
  logic run = 1'b0;
  logic stall = 1'b0;
  logic hi_val = 1'b0;
  logic [8:0] tidx [5] = '{9'h195, 9'h199, 9'h1a5, 9'h1a9, 9'h1ff};
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 mclk = ~mclk;
  e1os_top e1os_top_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .tx_line_clock_pin, .tx_serial_in_pin, .tx_bit_data, .tx_bit_valid, .tx_bit_ready, .rx_line_mode,
    .tx_line_mode, .rx_impedance_code, .tx_impedance_code, .line_buildout_code, .tuning_a_channel_one,
    .tuning_b_channel_one, .tuning_a_channel_two, .tuning_b_channel_two);
  e1os_line_model e1os_line_model_inst (.mclk, .rst, .run, .stall, .hi_val, .tx_bit_data, .tx_bit_valid,
    .tx_line_clock_pin, .tx_serial_in_pin, .tx_bit_ready);
  // ------
  // tasks
  // ------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic reset_dut();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
  endtask
  // one apb transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [8:0] i, input logic [31:0] d);
    apb(1'b1, {1'b0, i, 2'b00}, d);
  endtask
  task automatic rd(input logic [8:0] i, input logic [31:0] e, input string nm);
    apb(1'b0, {1'b0, i, 2'b00}, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic tune(input int c, input logic [7:0] a, input logic [7:0] b);
    wr(`E1OS_IDX_PAGE, 32'h1);
    wr(tidx[2*c], a);
    wr(tidx[2*c+1], b);
    wr(`E1OS_IDX_PAGE, 32'h0);
  endtask
  function automatic logic [7:0] fbyte(input int f);
    logic [7:0] b;
    for (int k = 0; k < 8; k++) b[7-k] = e1os_line_model_inst.bits[f*256+k];
    return b;
  endfunction
  // bit 0 of each frame goes out first, so the byte reads msb first
  task automatic frame_run(input logic [7:0] fc, oh, af, naf, ci, input logic hv, input logic [7:0] e2, m3, e3);
    reset_dut();
    wr(`E1OS_IDX_FRMCTL, fc);
    wr(`E1OS_IDX_OHSRC, oh);
    wr(`E1OS_IDX_AFR, af);
    wr(`E1OS_IDX_NAFR, naf);
    wr(`E1OS_IDX_CLKCTL, ci);
    wr(`E1OS_IDX_MODE, 32'h1);
    hi_val <= hv;
    run <= 1'b1;
    while (e1os_line_model_inst.nbits < 1024) @(posedge mclk);
    run <= 1'b0;
    chk("align frame", e2, fbyte(2));
    chk("nonalign frame", e3, fbyte(3) & m3);
    done("frame");
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      summarize();
    end
  end
  // ------
  // main sequence
  // ------
  initial begin
    logic acc;
    reset_dut();
    for (int i = 0; i < 15; i++) rd(9'(i), 32'h0, "reset value");
    for (int i = 0; i < 5; i++) rd(tidx[i], 32'h0, "reset value");
    rd(`E1OS_IDX_STATUS, 32'h18, "status reset");
    apb(1'b0, 12'h800, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, 12'h806, 32'h7);
    chk("misaligned error", 32'h1, {31'h0, rerr});
    rd(`E1OS_IDX_FRMCTL, 32'h0, "write ignored");
    done("registers");
    for (int m = 0; m < 4; m++) begin
      wr(`E1OS_IDX_MODE, 32'(m * 5));
      chk("rx mode", 32'(m), {30'h0, rx_line_mode});
      chk("tx mode", (m == 3) ? 32'h2 : 32'(m), {30'h0, tx_line_mode});
    end
    rd(`E1OS_IDX_MODE, 32'he, "mode readback");
    for (int k = 1; k >= 0; k--) begin
      wr(`E1OS_IDX_RXLINE, 32'(k * 3));
      chk("rx impedance", 32'(k * 3), {29'h0, rx_impedance_code});
      wr(`E1OS_IDX_TXLINE, k ? 32'hb : 32'h0);
      chk("tx line", k ? 32'hb : 32'h0, {26'h0, line_buildout_code, tx_impedance_code});
      rd(`E1OS_IDX_STATUS, k ? 32'h10 : 32'h18, "line cfg ok");
    end
    done("line modes");
    for (int c = 0; c < 2; c++) begin
      for (int v = 1; v >= 0; v--) begin
        tune(c, 8'hf8, v ? 8'h09 : 8'h00);
        chk("tuning a", 32'hf8, {24'h0, c ? tuning_a_channel_two : tuning_a_channel_one});
        chk("tuning b", 32'(v * 9), {24'h0, c ? tuning_b_channel_two : tuning_b_channel_one});
        rd(tidx[2*c+1], 32'(v * 9), "tuning readback");
      end
      wr(tidx[2*c], 32'h55);
      chk("closed page", 32'hf8, {24'h0, c ? tuning_a_channel_two : tuning_a_channel_one});
      wr(`E1OS_IDX_MODE, 32'h0);
      tune(c, 8'h00, 8'h00);
      chk("untuned", 32'h0, {16'h0, tuning_a_channel_one | tuning_a_channel_two,
        tuning_b_channel_one | tuning_b_channel_two});
    end
    done("tuning");
    frame_run(8'h04, 8'h04, 8'h9b, 8'hff, 8'h0, 1'b1, 8'h9b, 8'hff, 8'hef);
    rd(`E1OS_IDX_STATUS, 32'h19, "align flag");
    frame_run(8'h05, 8'h04, 8'hff, 8'hff, 8'h0, 1'b0, 8'h00, 8'h98, 8'h00);
    frame_run(8'h02, 8'h01, 8'hff, 8'hff, 8'h0, 1'b1, 8'h7f, 8'h98, 8'h18);
    frame_run(8'h05, 8'h00, 8'h00, 8'h00, 8'h1, 1'b0, 8'hff, 8'h98, 8'h98);
    reset_dut();
    wr(`E1OS_IDX_MODE, 32'h2);
    stall <= 1'b1;
    run <= 1'b1;
    rdat = 32'h0;
    for (int n = 0; n < 100 && rdat[2] !== 1'b1; n++) apb(1'b0, 12'h03c, 32'h0);
    run <= 1'b0;
    chk("overrun", 32'h4, rdat & 32'h4);
    chk("held valid", 32'h1, {31'h0, tx_bit_valid});
    stall <= 1'b0;
    while (tx_bit_valid !== 1'b0) @(posedge mclk);
    acc = 1'b1;
    for (int k = 0; k < e1os_line_model_inst.nbits; k++) acc &= e1os_line_model_inst.bits[k];
    chk("all ones", 32'h1, {31'h0, acc});
    chk("fifo depth", 32'h1, {31'h0, e1os_line_model_inst.nbits >= 16});
    wr(`E1OS_IDX_STATUS, 32'h4);
    apb(1'b0, 12'h03c, 32'h0);
    chk("overrun cleared", 32'h0, rdat & 32'h4);
    done("fifo");
    summarize();
  end
endmodule // e1os_top_bench
